// *** inc/swt_pkg.sv ***
// Constants shared by the switch drive timing generator
package swt_pkg;
    // Clock and base tick rate
    localparam int CLK_HZ = 50_000_000;
    localparam int BASE_TICK_PPS = 800;
    localparam int BASE_TICK_CYCLES = CLK_HZ / BASE_TICK_PPS;
    // Blanking pulse widths in microseconds and in cycles
    localparam int SHORT_BLANK_US = 10;
    localparam int LONG_BLANK_US = 400;
    localparam int CYCLES_PER_US = CLK_HZ / 1_000_000;
    localparam int SHORT_BLANK_CYCLES = SHORT_BLANK_US * CYCLES_PER_US;
    localparam int LONG_BLANK_CYCLES = LONG_BLANK_US * CYCLES_PER_US;
    // Divide-by-ten: five full 400 pps cycles per 40 pps half period
    localparam logic [2:0] DIV_LAST = 3'h4;
    // Channel count and widths
    localparam int NUM_CHAN = 3;
    localparam int PRESCALE_W = 16;
    localparam int BLANK_W = 15;
    localparam int PIN_W = 7 * NUM_CHAN;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] PRESCALE_OFFSET = 8'h04;
    localparam logic [7:0] COMMAND_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0C;
    // Control register fields and reset values
    localparam int CTRL_COMPUTER_BIT = 0;
    localparam logic CTRL_RESET = 1'b0;
    localparam logic [15:0] COMMAND_RESET = 16'h0000;
    // Command register field positions, one bit per channel
    localparam int CMD_MOD_LSB = 0;
    localparam int CMD_SWITCHED_LSB = 4;
    localparam int CMD_LOCK_LSB = 8;
    localparam int CMD_POL_LSB = 12;
    // Status register field positions
    localparam int ST_NOISE_LSB = 0;
    localparam int ST_CIRC_LSB = 4;
    localparam int ST_POL_LSB = 8;
    localparam int ST_SENSE_LSB = 12;
    localparam int ST_SWITCHED_LSB = 16;
    localparam int ST_LOAD_LSB = 20;
    localparam int ST_WAVE400_BIT = 24;
    localparam int ST_WAVE40_BIT = 25;
    // Bus slave states, one-hot
    typedef enum logic [1:0] {
        APB_IDLE = 2'b01,
        APB_ACCESS = 2'b10
    } apb_state_type;
endpackage : swt_pkg

// *** inc/timing_if.sv ***
// Carrier for the shared timing chain outputs
`timescale 1ns/1ps
interface timing_if;
    logic tick; // One-cycle base tick
    logic wave400; // 400 pps square wave
    logic wave40; // 40 pps square wave
    logic blank_short; // Short blanking pulse
    logic blank_long; // Long blanking pulse
    modport source (output tick, output wave400, output wave40, output blank_short, output blank_long);
    modport sink (input tick, input wave400, input wave40, input blank_short, input blank_long);
endinterface : timing_if

// *** rtl/timing_chain.sv ***
// Base tick prescaler, divider chain and blanking pulse generators
`timescale 1ns/1ps
module timing_chain import swt_pkg::*; #(
    parameter int LONG_CYCLES = LONG_BLANK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Tick period minus one
    input wire logic [PRESCALE_W-1:0] prescale,
    // Timing outputs
    timing_if.source tim
);
    logic [PRESCALE_W-1:0] cnt, next_cnt; // Prescaler
    logic tick, next_tick; // Base tick
    logic wave400, next_wave400; // First binary stage
    logic [2:0] div_cnt, next_div_cnt; // Divide-by-five counter, 0 to DIV_LAST
    logic wave40, next_wave40; // Final flip-flop
    logic [BLANK_W-1:0] sb_cnt, next_sb_cnt; // Short blank timer
    logic [BLANK_W-1:0] lb_cnt, next_lb_cnt; // Long blank timer

    // Next state of the whole chain
    always_comb begin
        next_cnt = cnt + 1'b1;
        next_tick = 1'b0;
        next_wave400 = wave400;
        next_div_cnt = div_cnt;
        next_wave40 = wave40;
        next_sb_cnt = (sb_cnt != '0) ? sb_cnt - 1'b1 : sb_cnt;
        next_lb_cnt = (lb_cnt != '0) ? lb_cnt - 1'b1 : lb_cnt;
        if (cnt >= prescale) begin
            next_cnt = '0;
            next_tick = 1'b1;
        end
        if (tick) begin
            next_wave400 = ~wave400;
            next_sb_cnt = BLANK_W'(SHORT_BLANK_CYCLES);
            // Count whole 400 pps cycles, toggling on the tick edge
            if (wave400) begin
                if (div_cnt == DIV_LAST) begin
                    next_div_cnt = '0;
                    next_wave40 = ~wave40;
                    next_lb_cnt = BLANK_W'(LONG_CYCLES);
                end else begin
                    next_div_cnt = div_cnt + 1'b1;
                end
            end
        end
    end

    // Chain registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt <= '0;
            tick <= 1'b0;
            wave400 <= 1'b0;
            div_cnt <= '0;
            wave40 <= 1'b0;
            sb_cnt <= '0;
            lb_cnt <= '0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
            wave400 <= next_wave400;
            div_cnt <= next_div_cnt;
            wave40 <= next_wave40;
            sb_cnt <= next_sb_cnt;
            lb_cnt <= next_lb_cnt;
        end
    end

    assign tim.tick = tick;
    assign tim.wave400 = wave400;
    assign tim.wave40 = wave40;
    assign tim.blank_short = (sb_cnt != '0);
    assign tim.blank_long = (lb_cnt != '0);
endmodule : timing_chain

// *** rtl/channel_ctrl.sv ***
// One channel of mode, modulation, circulator and polarization logic
`timescale 1ns/1ps
module channel_ctrl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Shared timing
    timing_if.sink tim,
    // Source selection and computer commands
    input wire logic computer,
    input wire logic comp_mod,
    input wire logic comp_switched,
    input wire logic comp_lock,
    input wire logic comp_pol,
    // Synchronised manual switches and sense return
    input wire logic man_mod,
    input wire logic mode_press,
    input wire logic noise_press,
    input wire logic release_press,
    input wire logic lock_press,
    input wire logic man_pol,
    input wire logic pol_sense,
    // Combinational drives and indicators
    output logic noise_drive,
    output logic circ_drive,
    output logic pol_drive,
    output logic ref_out,
    output logic blank_out,
    output logic load_ind,
    output logic signal_ind,
    output logic switched_ind,
    output logic sense_ind
);
    logic sw_latch, next_sw_latch; // Switched-mode latch
    logic noise_latch, next_noise_latch; // Noise hold latch
    logic lock_latch, next_lock_latch; // Circulator lock latch
    logic switched, mod_en, lock;

    // Latch updates; release and computer control win over a press
    always_comb begin
        next_sw_latch = sw_latch;
        next_noise_latch = noise_latch;
        next_lock_latch = lock_latch;
        if (computer || release_press) begin
            next_sw_latch = 1'b0;
            next_noise_latch = 1'b0;
            next_lock_latch = 1'b0;
        end else begin
            if (mode_press) next_sw_latch = 1'b1;
            if (noise_press) next_noise_latch = 1'b1;
            if (lock_press) next_lock_latch = 1'b1;
        end
    end

    // Latch registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sw_latch <= 1'b0;
            noise_latch <= 1'b0;
            lock_latch <= 1'b0;
        end else begin
            sw_latch <= next_sw_latch;
            noise_latch <= next_noise_latch;
            lock_latch <= next_lock_latch;
        end
    end

    // Only the energised source governs each function
    assign switched = computer ? comp_switched : sw_latch;
    assign mod_en = computer ? comp_mod : man_mod;
    assign lock = computer ? comp_lock : lock_latch;

    // Drive routing
    always_comb begin
        noise_drive = ~switched & (mod_en ? tim.wave400 : noise_latch);
        load_ind = ~switched & ~mod_en & ~noise_latch;
        circ_drive = lock ? 1'b0 : (switched ? tim.wave40 : 1'b1);
        signal_ind = ~lock;
        switched_ind = switched | lock;
        ref_out = switched ? tim.wave40 : tim.wave400;
        blank_out = switched ? tim.blank_long : tim.blank_short;
        pol_drive = computer ? comp_pol : man_pol;
        sense_ind = pol_sense;
    end
endmodule : channel_ctrl

// *** rtl/switch_drive_timing_generator.sv ***
// Top of the front-end switch drive timing generator with APB registers
// Functional notes
// - Base tick runs at 800 pps
// - Every tick starts a 10 us blank
// - First divide-by-two gives 400 pps reference
// - Divide 400 pps by ten to 40 pps
// - Each 40 pps edge starts 400 us blank
// - Mode picks 400 Hz/short or 40 Hz/long
// - Modulation gate passes 400 Hz to noise
// - Noise press holds noise on until release
// - Release or computer clears switched latch
// - Switched mode drives circulator at 40 Hz
// - Lock holds load until release/computer
// - Polarization select drives right-hand feed
// - Polarization indicator follows returned sense
// - Exactly one control source governs
// - Three identical channels share timing
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module switch_drive_timing_generator import swt_pkg::*; #(
    parameter logic [PRESCALE_W-1:0] TICK_CYCLES = PRESCALE_W'(BASE_TICK_CYCLES),
    parameter int LONG_CYCLES = LONG_BLANK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Manual front panel switches, one bit per channel
    input wire logic [NUM_CHAN-1:0] noise_mod_gate,
    input wire logic [NUM_CHAN-1:0] mode_select_input,
    input wire logic [NUM_CHAN-1:0] noise_force_input,
    input wire logic [NUM_CHAN-1:0] latch_release_input,
    input wire logic [NUM_CHAN-1:0] circulator_lock_input,
    input wire logic [NUM_CHAN-1:0] polarization_select_input,
    // Sense return from the remote polarization controller
    input wire logic [NUM_CHAN-1:0] polarization_sense,
    // Remote switch drives
    output logic [NUM_CHAN-1:0] noise_switch_drive,
    output logic [NUM_CHAN-1:0] circulator_drive,
    output logic [NUM_CHAN-1:0] polarization_drive,
    // Synchronous detector reference and blanking
    output logic [NUM_CHAN-1:0] sync_reference,
    output logic [NUM_CHAN-1:0] sync_blank,
    // Panel indicators
    output logic [NUM_CHAN-1:0] load_indicator,
    output logic [NUM_CHAN-1:0] signal_indicator,
    output logic [NUM_CHAN-1:0] switched_indicator,
    output logic [NUM_CHAN-1:0] polarization_sense_indicator,
    // Control source buses, both low in reset, then exactly one high
    output logic computer_bus,
    output logic manual_bus
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------

    apb_state_type state, next_state; // Bus slave state
    logic computer, next_computer; // Computer bus selected
    logic [PRESCALE_W-1:0] prescale, next_prescale; // Tick period minus one
    logic [15:0] command, next_command; // Computer commands
    logic [31:0] next_prdata; // Read data next value
    logic next_pready; // Access-phase answer
    logic next_pslverr; // Unmapped address flag
    logic [31:0] status; // Live block state
    logic mapped; // Address hits a register

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------

    logic [PIN_W-1:0] pins_raw; // Packed pin inputs
    logic [PIN_W-1:0] pins_meta; // First stage, read only by second
    logic [PIN_W-1:0] pins_sync; // Second stage, safe to use

    // Pack all panel and sense pins into one vector
    assign pins_raw = {polarization_sense, polarization_select_input, circulator_lock_input,
                       latch_release_input, noise_force_input, mode_select_input, noise_mod_gate};

    // Two-flop synchroniser; switches are slow so no debouncing is done here
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pins_meta <= '0;
            pins_sync <= '0;
        end else begin
            pins_meta <= pins_raw;
            pins_sync <= pins_meta;
        end
    end

    // ------------------------------------------------------------
    // Shared timing chain
    // ------------------------------------------------------------

    timing_if tim_bus ();

    // One chain feeds every channel so all rates stay in phase
    timing_chain #(
        .LONG_CYCLES(LONG_CYCLES)
    ) u_chain (
        .ref_clk(ref_clk),
        .rst(rst),
        .prescale(prescale),
        .tim(tim_bus.source)
    );

    // ------------------------------------------------------------
    // Per-channel control
    // ------------------------------------------------------------

    logic [NUM_CHAN-1:0] ch_noise; // Noise switch drive
    logic [NUM_CHAN-1:0] ch_circ; // Circulator drive
    logic [NUM_CHAN-1:0] ch_pol; // Polarization drive
    logic [NUM_CHAN-1:0] ch_ref; // Detector reference
    logic [NUM_CHAN-1:0] ch_blank; // Detector blanking
    logic [NUM_CHAN-1:0] ch_load; // Load indicator
    logic [NUM_CHAN-1:0] ch_signal; // Signal indicator
    logic [NUM_CHAN-1:0] ch_switched; // Circulator load lamp
    logic [NUM_CHAN-1:0] ch_sense; // Polarization sense lamp

    // Identical independent channels
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
        channel_ctrl u_ch (
            .ref_clk(ref_clk),
            .rst(rst),
            .tim(tim_bus.sink),
            .computer(computer),
            .comp_mod(command[CMD_MOD_LSB + ch]),
            .comp_switched(command[CMD_SWITCHED_LSB + ch]),
            .comp_lock(command[CMD_LOCK_LSB + ch]),
            .comp_pol(command[CMD_POL_LSB + ch]),
            .man_mod(pins_sync[ch]),
            .mode_press(pins_sync[NUM_CHAN + ch]),
            .noise_press(pins_sync[2 * NUM_CHAN + ch]),
            .release_press(pins_sync[3 * NUM_CHAN + ch]),
            .lock_press(pins_sync[4 * NUM_CHAN + ch]),
            .man_pol(pins_sync[5 * NUM_CHAN + ch]),
            .pol_sense(pins_sync[6 * NUM_CHAN + ch]),
            .noise_drive(ch_noise[ch]),
            .circ_drive(ch_circ[ch]),
            .pol_drive(ch_pol[ch]),
            .ref_out(ch_ref[ch]),
            .blank_out(ch_blank[ch]),
            .load_ind(ch_load[ch]),
            .signal_ind(ch_signal[ch]),
            .switched_ind(ch_switched[ch]),
            .sense_ind(ch_sense[ch])
        );
    end

    // Register every drive so outputs come straight from flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            noise_switch_drive <= '0;
            circulator_drive <= '0;
            polarization_drive <= '0;
            sync_reference <= '0;
            sync_blank <= '0;
            load_indicator <= '0;
            signal_indicator <= '0;
            switched_indicator <= '0;
            polarization_sense_indicator <= '0;
            computer_bus <= 1'b0;
            manual_bus <= 1'b0;
        end else begin
            noise_switch_drive <= ch_noise;
            circulator_drive <= ch_circ;
            polarization_drive <= ch_pol;
            sync_reference <= ch_ref;
            sync_blank <= ch_blank;
            load_indicator <= ch_load;
            signal_indicator <= ch_signal;
            switched_indicator <= ch_switched;
            polarization_sense_indicator <= ch_sense;
            computer_bus <= computer;
            manual_bus <= ~computer;
        end
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------

    // Live drive state as seen on the output flops
    always_comb begin
        status = '0;
        status[ST_NOISE_LSB +: NUM_CHAN] = noise_switch_drive;
        status[ST_CIRC_LSB +: NUM_CHAN] = circulator_drive;
        status[ST_POL_LSB +: NUM_CHAN] = polarization_drive;
        status[ST_SENSE_LSB +: NUM_CHAN] = polarization_sense_indicator;
        status[ST_SWITCHED_LSB +: NUM_CHAN] = switched_indicator;
        status[ST_LOAD_LSB +: NUM_CHAN] = load_indicator;
        status[ST_WAVE400_BIT] = tim_bus.wave400;
        status[ST_WAVE40_BIT] = tim_bus.wave40;
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------

    // Decode of the four word registers
    assign mapped = (paddr == CTRL_OFFSET) || (paddr == PRESCALE_OFFSET) ||
                    (paddr == COMMAND_OFFSET) || (paddr == STATUS_OFFSET);

    // Bus next state: no wait states, answer in the cycle after setup
    always_comb begin
        next_state = state;
        next_computer = computer;
        next_prescale = prescale;
        next_command = command;
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        case (state)
            APB_IDLE: begin
                // Setup phase seen: prepare the answer
                if (psel && !penable) begin
                    next_state = APB_ACCESS;
                    next_pready = 1'b1;
                    next_pslverr = ~mapped;
                    next_prdata = '0;
                    if (!pwrite) begin
                        case (paddr)
                            CTRL_OFFSET: next_prdata[CTRL_COMPUTER_BIT] = computer;
                            PRESCALE_OFFSET: next_prdata[PRESCALE_W-1:0] = prescale;
                            COMMAND_OFFSET: next_prdata[15:0] = command;
                            STATUS_OFFSET: next_prdata = status;
                            default: next_prdata = '0;
                        endcase
                    end
                end
            end
            APB_ACCESS: begin
                // Completion edge: writes land here and nowhere else
                next_state = APB_IDLE;
                if (psel && penable && pwrite) begin
                    case (paddr)
                        CTRL_OFFSET: next_computer = pwdata[CTRL_COMPUTER_BIT];
                        PRESCALE_OFFSET: next_prescale = pwdata[PRESCALE_W-1:0];
                        COMMAND_OFFSET: next_command = pwdata[15:0];
                        default: next_command = command;
                    endcase
                end
            end
            default: begin
                // Recover from an illegal code
                next_state = APB_IDLE;
            end
        endcase
    end

    // Bus and register flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= APB_IDLE;
            computer <= CTRL_RESET;
            prescale <= TICK_CYCLES - 1'b1;
            command <= COMMAND_RESET;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            state <= next_state;
            computer <= next_computer;
            prescale <= next_prescale;
            command <= next_command;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule : switch_drive_timing_generator

// *** test/swt_checker.sv ***
// Port-level assertion checker for the switch drive timing generator
`timescale 1ns/1ps
module swt_checker import swt_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Bus handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Channel pins and outputs
    input wire logic [NUM_CHAN-1:0] polarization_select_input,
    input wire logic [NUM_CHAN-1:0] polarization_sense,
    input wire logic [NUM_CHAN-1:0] polarization_drive,
    input wire logic [NUM_CHAN-1:0] circulator_drive,
    input wire logic [NUM_CHAN-1:0] sync_reference,
    input wire logic [NUM_CHAN-1:0] noise_switch_drive,
    input wire logic [NUM_CHAN-1:0] load_indicator,
    input wire logic [NUM_CHAN-1:0] signal_indicator,
    input wire logic [NUM_CHAN-1:0] switched_indicator,
    input wire logic [NUM_CHAN-1:0] polarization_sense_indicator,
    // Control source buses
    input wire logic computer_bus,
    input wire logic manual_bus
);
    // Edges since reset; outputs are still all low just after release
    logic [1:0] age;
    logic [1:0] next_age;
    // Saturating age count
    always_comb begin
        next_age = (age == 2'h3) ? age : age + 2'h1;
    end
    always_ff @(posedge ref_clk) begin
        age <= rst ? 2'h0 : next_age;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_one_source: assert property (age == 2'h3 |-> computer_bus ^ manual_bus)
        else $error("control buses not exactly one high");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no answer in the access cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside the access cycle");
    a_pol_follows_pin: assert property ((manual_bus && polarization_select_input[0])[*5] |-> polarization_drive[0])
        else $error("polarization drive ignores its select pin");
    a_sense_indicator: assert property ($stable(polarization_sense[0])[*5] |-> polarization_sense_indicator[0] == polarization_sense[0])
        else $error("sense indicator differs from returned sense");
    a_lock_forces_load: assert property (age == 2'h3 && !signal_indicator[0] |-> !circulator_drive[0] && switched_indicator[0])
        else $error("locked circulator not at load");
    a_switched_drive: assert property (switched_indicator[0] && signal_indicator[0] |-> circulator_drive[0] == sync_reference[0] && !load_indicator[0])
        else $error("switched circulator drive off the reference");
    a_load_no_noise: assert property (load_indicator[0] |-> !noise_switch_drive[0])
        else $error("noise drive on while load shown");
endmodule : swt_checker
bind switch_drive_timing_generator swt_checker u_swt_checker (.*);

// *** test/pol_sense_model.sv ***
// Remote polarization controller returning a current sense
`timescale 1ns/1ps
module pol_sense_model import swt_pkg::*; (
    // Clock
    input wire logic ref_clk,
    // Drive from the block, and an open-circuit fault on command
    input wire logic [NUM_CHAN-1:0] polarization_drive,
    input wire logic stuck,
    // Returned sense, pulled low when no current flows
    output logic [NUM_CHAN-1:0] polarization_sense
);
    // Two-cycle relay pull-in
    logic [NUM_CHAN-1:0] energized = '0;
    initial polarization_sense = '0;
    always @(posedge ref_clk) begin
        energized <= polarization_drive;
        polarization_sense <= stuck ? '0 : energized;
    end
endmodule : pol_sense_model

// *** test/tb.sv ***
// Self-checking bench for the switch drive timing generator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb import swt_pkg::*; ;
    // Shortened tick and long blank keep the run brief
    localparam logic [15:0] TICK = 16'h0258;
    localparam int LONG = 800;
    // Status fields that stay settled; live waves are masked off
    localparam logic [31:0] MASK = 32'h0077_7700;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stuck = 1'b0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, cmd;
    logic [NUM_CHAN-1:0] noise_mod_gate = '0, mode_select_input = '0, noise_force_input = '0, pp;
    logic [NUM_CHAN-1:0] latch_release_input = '0, circulator_lock_input = '0, polarization_select_input = '0;
    logic [NUM_CHAN-1:0] polarization_sense, noise_switch_drive, circulator_drive, polarization_drive;
    logic [NUM_CHAN-1:0] sync_reference, sync_blank, load_indicator, signal_indicator, switched_indicator;
    logic [NUM_CHAN-1:0] polarization_sense_indicator;
    logic computer_bus, manual_bus;
    int fails = 0, check_count = 0, cycles = 0, seed = 32'hAB39, n;
    switch_drive_timing_generator #(.TICK_CYCLES(TICK), .LONG_CYCLES(LONG)) u_switch_drive_timing_generator (.*);
    pol_sense_model u_pol_sense_model (.*);
    always #10 ref_clk = ~ref_clk;
    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 90000) begin
            fails++;
            summarize();
        end
    end
    task summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // One bus transfer; waits for pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Press one panel switch, then wait past the synchronisers
    task press(input int k, input logic [NUM_CHAN-1:0] m);
        @(posedge ref_clk);
        case (k)
            0: mode_select_input <= m;
            1: noise_force_input <= m;
            2: latch_release_input <= m;
            default: circulator_lock_input <= m;
        endcase
        repeat (4) @(posedge ref_clk);
        {mode_select_input, noise_force_input, latch_release_input, circulator_lock_input} <= '0;
        repeat (8) @(posedge ref_clk);
    endtask : press
    // Reference model of the settled status fields
    function automatic logic [31:0] model(input logic [2:0] s, l, m, h, p, q);
        return {9'h000, ~s & ~m & ~h, 1'b0, s | l, 1'b0, q, 1'b0, p, 8'h00};
    endfunction : model
    task status(input logic [31:0] e);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        `CHK("status", e, rd & MASK)
    endtask : status
    // High run of channel 0 reference or blank, in cycles
    task meas(input logic b);
        n = 0;
        for (int ph = 0; ph < 3; ph++) begin
            while (((b ? sync_blank[0] : sync_reference[0]) === 1'b1) != (ph == 1)) begin
                @(posedge ref_clk);
                n += (ph == 2);
            end
        end
    endtask : meas
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        `CHK("ctrl", 32'h0, rd)
        apb(1'b0, PRESCALE_OFFSET, 32'h0);
        `CHK("prescale", 32'h257, rd)
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 2'b10, {err, |rd})
        `CHK("buses", 2'b01, {computer_bus, manual_bus})
        $display("test registers done");
        pp = 3'($random(seed)) | 3'h1;
        polarization_select_input <= pp;
        press(1, 3'h1);
        status(model(3'h0, 3'h0, 3'h0, 3'h1, pp, pp));
        `CHK("noise hold", 1'b1, noise_switch_drive[0])
        press(2, 3'h1);
        status(model(3'h0, 3'h0, 3'h0, 3'h0, pp, pp));
        $display("test manual hold done");
        noise_mod_gate <= 3'h7;
        meas(1'b0);
        `CHK("fast half", int'(TICK), n)
        meas(1'b1);
        `CHK("short blank", SHORT_BLANK_CYCLES, n)
        `CHK("noise", 2'b11, {noise_switch_drive[0], sync_reference[0]})
        press(0, 3'h1);
        meas(1'b0);
        `CHK("slow half", 10 * int'(TICK), n)
        meas(1'b1);
        `CHK("long blank", LONG, n)
        status(model(3'h1, 3'h0, 3'h7, 3'h0, pp, pp));
        press(3, 3'h1);
        status(model(3'h1, 3'h1, 3'h7, 3'h0, pp, pp));
        `CHK("lock", 2'b00, {circulator_drive[0], signal_indicator[0]})
        press(2, 3'h1);
        status(model(3'h0, 3'h0, 3'h7, 3'h0, pp, pp));
        $display("test modes done");
        press(0, 3'h2);
        press(3, 3'h4);
        apb(1'b1, CTRL_OFFSET, 32'h1);
        repeat (10) @(posedge ref_clk);
        `CHK("buses", 2'b10, {computer_bus, manual_bus})
        status(model(3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0));
        repeat (4) begin
            cmd = $random(seed) & 32'h7777;
            apb(1'b1, COMMAND_OFFSET, cmd);
            repeat (10) @(posedge ref_clk);
            status(model(cmd[6:4], cmd[10:8], cmd[2:0], 3'h0, cmd[14:12], cmd[14:12]));
        end
        stuck <= 1'b1;
        apb(1'b1, COMMAND_OFFSET, 32'h7000);
        repeat (10) @(posedge ref_clk);
        status(model(3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h0));
        apb(1'b1, CTRL_OFFSET, 32'h0);
        status(model(3'h0, 3'h0, 3'h7, 3'h0, pp, 3'h0));
        $display("test computer control done");
        summarize();
    end
endmodule : tb
